// ### inc/tsa_pkg.sv
/*
  Shared constants and types of the timeslot access block: register map, field positions,
  reset values and the bus request and answer structures.
  Assumes a 32-bit AXI4-Lite master with byte addresses of 8 bits.
*/
package tsa_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_FIRST_SLOT_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SECOND_SLOT_CONFIG = 8'h04;
  localparam logic [7:0] OFS_FIFO_SLOT_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STROBE_CONTROL_ONE = 8'h0C;
  localparam logic [7:0] OFS_STROBE_CONTROL_TWO = 8'h10;
  localparam logic [7:0] OFS_STROBE_CONFIGURATION = 8'h14;
  localparam logic [7:0] OFS_MONITOR_CONTROL = 8'h18;
  localparam logic [7:0] OFS_MONITOR_TX = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POS_LINE_SELECT = 7;
  localparam int POS_SHORT_LINE = 3;
  localparam int POS_FIRST_EN = 4;
  localparam int POS_SECOND_EN = 5;
  localparam int POS_SHORT_EN = 6;
  localparam int POS_STROBE_EN = 8;
  localparam int POS_MON_LINE = 3;
  localparam int POS_MON_EN = 4;
  localparam int POS_MON_TERMINAL = 5;
  localparam int POS_MON_SLAVE = 6;
  localparam int POS_OVERFLOW = 8;
  localparam int POS_BIT_COUNT = 16;
  // ****************************************************************
  // Reset values and constants
  // ****************************************************************
  localparam logic LINE_DOWN = 1'b0;
  localparam logic [6:0] MONITOR_CONTROL_RESET = 7'h10;
  localparam logic [1:0] SHORT_SLOT_BITS = 2'h2;
  localparam logic [1:0] SLOT_IN_CHANNEL_MON = 2'h2;
  localparam logic [1:0] SLOT_IN_CHANNEL_SHORT = 2'h3;
  localparam logic [2:0] TERMINAL_CHANNELS = 3'h3;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } tsa_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tsa_axi_rsp_t;
endpackage : tsa_pkg

// ### rtl/tsa_sync.sv
/*
  Two-stage synchroniser for levels that arrive from outside the core clock domain.
  Assumes the inputs are levels held for several core clock periods.
*/
`timescale 1ns/1ps
module tsa_sync #(
  parameter int WIDTH = 1
) (
  input wire logic coreClk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge coreClk) begin
    if (srst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= meta_d;
      syncOut <= sync_d;
    end
  end
endmodule : tsa_sync

// ### rtl/tsa_fifo.sv
/*
  Synchronous first-in first-out buffer with valid and ready on both sides.
  Assumes one clock; depth is a power of two.
*/
`timescale 1ns/1ps
module tsa_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input wire logic coreClk,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] wrPtr_d;
  logic [AW:0] rdPtr_q;
  logic [AW:0] rdPtr_d;
  logic push;
  logic pop;

  always_comb begin
    inReady = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
    outValid = wrPtr_q != rdPtr_q;
    outData = mem_q[rdPtr_q[AW-1:0]];
    push = inValid && inReady;
    pop = outValid && outReady;
    wrPtr_d = wrPtr_q + (AW+1)'(push);
    rdPtr_d = rdPtr_q + (AW+1)'(pop);
  end

  always_ff @(posedge coreClk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
    if (push) begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end
endmodule : tsa_fifo

// ### rtl/tsa_top.sv
/*
  Timeslot access block of a frame-synchronous serial bus: FIFO timeslot mapping,
  two strobe outputs and monitor channel selection, configured over AXI4-Lite.
  Assumes bus clock, frame sync and data lines arrive asynchronously to core_clk and
  that the double-rate bus clock is slower than a quarter of core_clk.
*/
// Implementation choices: the address map and register access over AXI4-Lite.
// Behaviour
// [RULE_01] FIFO uses two byte slots, one two-bit slot.
// [RULE_02] Each slot has own number and line.
// [RULE_03] Each slot enabled alone; 2..18 bits/frame.
// [RULE_04] Byte slots: number field plus line bit.
// [RULE_05] Short slot: channel, line, three enables.
// [RULE_06] Bus slot bits to line, line bits back.
// [RULE_07] One bus frame maps to same line frame.
// [RULE_08] Two strobe outputs: strobe or gated clock.
// [RULE_09] Strobe on TS, TS+1, TS+3, each enabled.
// [RULE_10] TS, TS+1 eight bits; TS+3 two bits.
// [RULE_11] Gated clock passes only in window, else low.
// [RULE_12] Per-output bit selects gated clock mode.
// [RULE_13] Monitor channel: three terminal, eight otherwise.
// [RULE_14] Monitor line select and enable bit.
// [RULE_15] Reset: monitor channel 0, enabled, downstream.
// [RULE_16] Monitor links one master and one slave.
// [RULE_17] One bus bit is two double-rate clocks.
// [RULE_18] Bit counter cleared by sync, per bit.
`timescale 1ns/1ps
module tsa_top
  import tsa_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire tsa_axi_req_t axiReq,
  output tsa_axi_rsp_t axiRsp,
  input wire logic doubleRateClock,
  input wire logic frameSync,
  input wire logic upstreamLineIn,
  output logic upstreamLineOut,
  output logic upstreamLineOe,
  input wire logic downstreamLineIn,
  output logic downstreamLineOut,
  output logic downstreamLineOe,
  output logic strobeOutOne,
  output logic strobeOutTwo,
  output logic lineTxValid,
  input wire logic lineTxReady,
  output logic [1:0] lineTxData,
  input wire logic lineRxValid,
  output logic lineRxReady,
  input wire logic lineRxData
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic logic strobeWin(input logic [4:0] slot, input logic [2:0] idx,
                                     input logic [10:0] ctl);
    logic [4:0] ts;
    ts = ctl[4:0];
    return (ctl[POS_STROBE_EN] && slot == ts)
      || (ctl[POS_STROBE_EN+1] && slot == 5'(ts + 5'h1))
      || (ctl[POS_STROBE_EN+2] && slot == 5'(ts + 5'h3) && idx < 3'(SHORT_SLOT_BITS));
  endfunction : strobeWin

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pinSync;
  logic dclS;
  logic fscS;
  logic upS;
  logic downS;

  tsa_sync #(.WIDTH(4)) uSync (
    .coreClk(core_clk),
    .srst(srst),
    .asyncIn({doubleRateClock, frameSync, upstreamLineIn, downstreamLineIn}),
    .syncOut(pinSync)
  );

  always_comb begin
    {dclS, fscS, upS, downS} = pinSync;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] firstCfg_q, firstCfg_d, secondCfg_q, secondCfg_d;
  logic [6:0] fifoCtl_q, fifoCtl_d;
  logic [10:0] strobeCtlOne_q, strobeCtlOne_d, strobeCtlTwo_q, strobeCtlTwo_d;
  logic [1:0] strobeConf_q, strobeConf_d;
  logic [6:0] monCtl_q, monCtl_d;
  logic [7:0] monTx_q, monTx_d;
  logic overflow_q, overflow_d;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  tsa_axi_rsp_t rsp_q, rsp_d;
  logic doWrite;
  logic [31:0] wm;
  logic [7:0] monRx_q;
  logic [7:0] bitCnt_q;
  logic overflowSet;

  always_comb begin
    firstCfg_d = firstCfg_q;
    secondCfg_d = secondCfg_q;
    fifoCtl_d = fifoCtl_q;
    strobeCtlOne_d = strobeCtlOne_q;
    strobeCtlTwo_d = strobeCtlTwo_q;
    strobeConf_d = strobeConf_q;
    monCtl_d = monCtl_q;
    monTx_d = monTx_q;
    overflow_d = overflow_q;
    awHeld_d = awHeld_q || (axiReq.awvalid && rsp_q.awready);
    wHeld_d = wHeld_q || (axiReq.wvalid && rsp_q.wready);
    awAddr_d = (axiReq.awvalid && rsp_q.awready) ? axiReq.awaddr : awAddr_q;
    wData_d = (axiReq.wvalid && rsp_q.wready) ? axiReq.wdata : wData_q;
    wStrb_d = (axiReq.wvalid && rsp_q.wready) ? axiReq.wstrb : wStrb_q;
    rsp_d = rsp_q;
    doWrite = awHeld_q && wHeld_q && !rsp_q.bvalid;
    wm = merge(32'h0000_0000, wData_q, wStrb_q);
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      rsp_d.bvalid = 1'b1;
      rsp_d.bresp = RESP_OKAY;
      unique case (awAddr_q) // [RULE_04] [RULE_05] [RULE_12]
        OFS_FIRST_SLOT_CONFIG: firstCfg_d = 8'(merge(32'(firstCfg_q), wData_q, wStrb_q));
        OFS_SECOND_SLOT_CONFIG: secondCfg_d = 8'(merge(32'(secondCfg_q), wData_q, wStrb_q));
        OFS_FIFO_SLOT_CONTROL: fifoCtl_d = 7'(merge(32'(fifoCtl_q), wData_q, wStrb_q));
        OFS_STROBE_CONTROL_ONE: strobeCtlOne_d = 11'(merge(32'(strobeCtlOne_q), wData_q, wStrb_q));
        OFS_STROBE_CONTROL_TWO: strobeCtlTwo_d = 11'(merge(32'(strobeCtlTwo_q), wData_q, wStrb_q));
        OFS_STROBE_CONFIGURATION: strobeConf_d = 2'(merge(32'(strobeConf_q), wData_q, wStrb_q));
        OFS_MONITOR_CONTROL: monCtl_d = 7'(merge(32'(monCtl_q), wData_q, wStrb_q)); // [RULE_14]
        OFS_MONITOR_TX: monTx_d = 8'(merge(32'(monTx_q), wData_q, wStrb_q));
        OFS_STATUS: overflow_d = overflow_q && !wm[POS_OVERFLOW];
        default: rsp_d.bresp = RESP_DECERR;
      endcase
    end
    if (overflowSet) begin
      overflow_d = 1'b1;
    end
    if (rsp_q.bvalid && axiReq.bready) begin
      rsp_d.bvalid = 1'b0;
    end
    rsp_d.awready = !awHeld_d;
    rsp_d.wready = !wHeld_d;
    if (rsp_q.rvalid && axiReq.rready) begin
      rsp_d.rvalid = 1'b0;
    end
    if (axiReq.arvalid && rsp_q.arready) begin
      rsp_d.rvalid = 1'b1;
      rsp_d.rresp = RESP_OKAY;
      unique case (axiReq.araddr)
        OFS_FIRST_SLOT_CONFIG: rsp_d.rdata = {24'h0, firstCfg_q};
        OFS_SECOND_SLOT_CONFIG: rsp_d.rdata = {24'h0, secondCfg_q};
        OFS_FIFO_SLOT_CONTROL: rsp_d.rdata = {25'h0, fifoCtl_q};
        OFS_STROBE_CONTROL_ONE: rsp_d.rdata = {21'h0, strobeCtlOne_q};
        OFS_STROBE_CONTROL_TWO: rsp_d.rdata = {21'h0, strobeCtlTwo_q};
        OFS_STROBE_CONFIGURATION: rsp_d.rdata = {30'h0, strobeConf_q};
        OFS_MONITOR_CONTROL: rsp_d.rdata = {25'h0, monCtl_q};
        OFS_MONITOR_TX: rsp_d.rdata = {24'h0, monTx_q};
        OFS_STATUS: rsp_d.rdata = {8'h00, bitCnt_q, 7'h00, overflow_q, monRx_q};
        default: begin
          rsp_d.rdata = 32'h0000_0000;
          rsp_d.rresp = RESP_DECERR;
        end
      endcase
    end
    rsp_d.arready = !rsp_d.rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      firstCfg_q <= 8'h00;
      secondCfg_q <= 8'h00;
      fifoCtl_q <= 7'h00;
      strobeCtlOne_q <= 11'h000;
      strobeCtlTwo_q <= 11'h000;
      strobeConf_q <= 2'h0;
      monCtl_q <= MONITOR_CONTROL_RESET; // [RULE_15]
      monTx_q <= 8'hFF;
      overflow_q <= 1'b0;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      rsp_q <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
    end else begin
      firstCfg_q <= firstCfg_d;
      secondCfg_q <= secondCfg_d;
      fifoCtl_q <= fifoCtl_d;
      strobeCtlOne_q <= strobeCtlOne_d;
      strobeCtlTwo_q <= strobeCtlTwo_d;
      strobeConf_q <= strobeConf_d;
      monCtl_q <= monCtl_d;
      monTx_q <= monTx_d;
      overflow_q <= overflow_d;
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      rsp_q <= rsp_d;
    end
  end

  always_comb begin
    axiRsp = rsp_q;
  end

  // ****************************************************************
  // Frame timing
  // ****************************************************************
  // Frame sync is looked at only on double-rate clock edges, so a glitch between edges
  // cannot restart the frame.
  logic dclPrev_q, dclPrev_d, fscPrev_q, fscPrev_d, phase_q, phase_d, newBit_q, newBit_d;
  logic [7:0] bitCnt_d;
  logic dclRise, sampleNow;
  logic [4:0] slot;
  logic [2:0] idx;

  always_comb begin
    dclRise = dclS && !dclPrev_q;
    dclPrev_d = dclS;
    fscPrev_d = dclRise ? fscS : fscPrev_q;
    phase_d = phase_q;
    bitCnt_d = bitCnt_q;
    newBit_d = 1'b0;
    sampleNow = dclRise && !phase_q && !(fscS && !fscPrev_q);
    if (dclRise && fscS && !fscPrev_q) begin
      bitCnt_d = 8'h00; // [RULE_18]
      phase_d = 1'b0;
      newBit_d = 1'b1;
    end else if (dclRise) begin
      phase_d = !phase_q; // [RULE_17]
      if (phase_q) begin
        bitCnt_d = 8'(bitCnt_q + 8'h01); // [RULE_18]
        newBit_d = 1'b1;
      end
    end
    slot = bitCnt_q[7:3];
    idx = bitCnt_q[2:0];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dclPrev_q <= 1'b0;
      fscPrev_q <= 1'b0;
      phase_q <= 1'b0;
      bitCnt_q <= 8'h00;
      newBit_q <= 1'b0;
    end else begin
      dclPrev_q <= dclPrev_d;
      fscPrev_q <= fscPrev_d;
      phase_q <= phase_d;
      bitCnt_q <= bitCnt_d;
      newBit_q <= newBit_d;
    end
  end

  // ****************************************************************
  // FIFO slots, monitor channel and line drivers
  // ****************************************************************
  logic firstHit, secondHit, shortHit, anyHit, hitLine, monHit, monTxLine;
  logic frameFirst_q, frameFirst_d, pushValid_q, pushValid_d, fifoInReady;
  logic [1:0] pushData_q, pushData_d;
  logic txBit_q, txBit_d, rxReady_q, rxReady_d;
  logic [7:0] monShift_q, monShift_d, monRx_d;
  logic upOut_d, upOe_d, downOut_d, downOe_d, rxLineBit;

  always_comb begin
    firstHit = fifoCtl_q[POS_FIRST_EN] && slot == firstCfg_q[4:0]; // [RULE_01] [RULE_03]
    secondHit = fifoCtl_q[POS_SECOND_EN] && slot == secondCfg_q[4:0]; // [RULE_01] [RULE_03]
    shortHit = fifoCtl_q[POS_SHORT_EN] && slot == {fifoCtl_q[2:0], SLOT_IN_CHANNEL_SHORT}
      && idx < 3'(SHORT_SLOT_BITS); // [RULE_01] [RULE_03]
    anyHit = firstHit || secondHit || shortHit;
    hitLine = firstHit ? firstCfg_q[POS_LINE_SELECT]
      : secondHit ? secondCfg_q[POS_LINE_SELECT] : fifoCtl_q[POS_SHORT_LINE]; // [RULE_02]
    monHit = monCtl_q[POS_MON_EN] && slot == {monCtl_q[2:0], SLOT_IN_CHANNEL_MON}
      && (!monCtl_q[POS_MON_TERMINAL] || monCtl_q[2:0] < TERMINAL_CHANNELS); // [RULE_13] [RULE_14]
    monTxLine = monCtl_q[POS_MON_LINE] ^ monCtl_q[POS_MON_SLAVE]; // [RULE_16]
    rxLineBit = 1'b0;
    frameFirst_d = (newBit_q && bitCnt_q == 8'h00) ? 1'b1 : frameFirst_q;
    pushValid_d = 1'b0;
    pushData_d = pushData_q;
    overflowSet = 1'b0;
    monShift_d = monShift_q;
    monRx_d = monRx_q;
    if (sampleNow && anyHit) begin
      rxLineBit = (hitLine == LINE_DOWN) ? downS : upS; // [RULE_06]
      pushValid_d = fifoInReady;
      pushData_d = {frameFirst_q, rxLineBit}; // [RULE_07]
      overflowSet = !fifoInReady;
      frameFirst_d = 1'b0;
    end
    if (sampleNow && monHit) begin
      monShift_d = {monShift_q[6:0], (monTxLine == LINE_DOWN) ? upS : downS};
      if (idx == 3'h7) begin
        monRx_d = {monShift_q[6:0], (monTxLine == LINE_DOWN) ? upS : downS};
      end
    end
    rxReady_d = newBit_q && anyHit && !rxReady_q; // [RULE_06]
    txBit_d = txBit_q;
    if (rxReady_q) begin
      txBit_d = lineRxValid ? lineRxData : 1'b1;
    end
    upOut_d = 1'b1;
    upOe_d = 1'b0;
    downOut_d = 1'b1;
    downOe_d = 1'b0;
    if (anyHit) begin
      if (hitLine == LINE_DOWN) begin
        upOut_d = txBit_q;
        upOe_d = 1'b1;
      end else begin
        downOut_d = txBit_q;
        downOe_d = 1'b1;
      end
    end else if (monHit) begin
      if (monTxLine == LINE_DOWN) begin
        downOut_d = monTx_q[3'h7 - idx];
        downOe_d = 1'b1;
      end else begin
        upOut_d = monTx_q[3'h7 - idx];
        upOe_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      frameFirst_q <= 1'b0;
      pushValid_q <= 1'b0;
      pushData_q <= 2'h0;
      txBit_q <= 1'b1;
      lineRxReady <= 1'b0;
      rxReady_q <= 1'b0;
      monShift_q <= 8'h00;
      monRx_q <= 8'h00;
      upstreamLineOut <= 1'b1;
      upstreamLineOe <= 1'b0;
      downstreamLineOut <= 1'b1;
      downstreamLineOe <= 1'b0;
    end else begin
      frameFirst_q <= frameFirst_d;
      pushValid_q <= pushValid_d;
      pushData_q <= pushData_d;
      txBit_q <= txBit_d;
      lineRxReady <= rxReady_d;
      rxReady_q <= rxReady_d;
      monShift_q <= monShift_d;
      monRx_q <= monRx_d;
      upstreamLineOut <= upOut_d;
      upstreamLineOe <= upOe_d;
      downstreamLineOut <= downOut_d;
      downstreamLineOe <= downOe_d;
    end
  end

  // Lost bits set the sticky overflow flag rather than stalling: the bus cannot wait.
  logic fifoOutValid;
  logic [1:0] fifoOutData;
  logic popNow;

  tsa_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) uFifo (
    .coreClk(core_clk),
    .srst(srst),
    .inValid(pushValid_q),
    .inReady(fifoInReady),
    .inData(pushData_q),
    .outValid(fifoOutValid),
    .outReady(popNow),
    .outData(fifoOutData)
  );

  always_comb begin
    popNow = fifoOutValid && (!lineTxValid || lineTxReady);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lineTxValid <= 1'b0;
      lineTxData <= 2'h0;
    end else if (popNow) begin
      lineTxValid <= 1'b1;
      lineTxData <= fifoOutData; // [RULE_06]
    end else if (lineTxReady) begin
      lineTxValid <= 1'b0;
    end
  end

  // ****************************************************************
  // Strobe outputs
  // ****************************************************************
  logic strobeOne_d, strobeTwo_d;

  always_comb begin
    strobeOne_d = strobeWin(slot, idx, strobeCtlOne_q) // [RULE_09] [RULE_10]
      && (!strobeConf_q[0] || phase_q); // [RULE_11] [RULE_12]
    strobeTwo_d = strobeWin(slot, idx, strobeCtlTwo_q) // [RULE_08] [RULE_10]
      && (!strobeConf_q[1] || phase_q); // [RULE_11] [RULE_12]
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      strobeOutOne <= 1'b0;
      strobeOutTwo <= 1'b0;
    end else begin
      strobeOutOne <= strobeOne_d;
      strobeOutTwo <= strobeTwo_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence sFrameStart;
    dclRise && fscS && !fscPrev_q;
  endsequence

  a_frame_clear: assert property (sFrameStart |=> bitCnt_q == 8'h00 && !phase_q) // [RULE_18]
    else $error("Bit counter not cleared at frame sync.");
  a_bit_two_edges: assert property (dclRise && phase_q && !(fscS && !fscPrev_q)
    |=> bitCnt_q == 8'($past(bitCnt_q) + 8'h01)) // [RULE_17]
    else $error("Bit counter did not advance on second edge.");
  a_strobe_low: assert property (!strobeWin(slot, idx, strobeCtlOne_q) |=> !strobeOutOne) // [RULE_11]
    else $error("Strobe one active outside window.");
  a_short_window: assert property (slot == 5'(strobeCtlTwo_q[4:0] + 5'h3)
    && idx >= 3'h2 |=> !strobeOutTwo) // [RULE_10]
    else $error("Third-slot strobe longer than two bits.");
  a_data_strobe: assert property (!strobeConf_q[0] && strobeWin(slot, idx, strobeCtlOne_q)
    |=> strobeOutOne) // [RULE_12]
    else $error("Data strobe missing in window.");
  a_short_slot: assert property (!fifoCtl_q[POS_FIRST_EN] && !fifoCtl_q[POS_SECOND_EN]
    && idx > 3'h1 |-> !anyHit) // [RULE_03]
    else $error("Short slot took more than two bits.");
  a_monitor_reset: assert property ($rose(!srst) |-> monCtl_q == MONITOR_CONTROL_RESET) // [RULE_15]
    else $error("Monitor control reset value wrong.");
  a_fifo_push: assert property (sampleNow && anyHit && fifoInReady |=> pushValid_q
    ##1 !pushValid_q) // [RULE_06]
    else $error("Sampled slot bit not pushed once.");
  a_monitor_off: assert property (!monHit && !anyHit
    |=> !upstreamLineOe && !downstreamLineOe) // [RULE_14]
    else $error("Monitor driven while disabled.");
endmodule : tsa_top

// ### bench/tsa_bus_model.sv
/* Far side of the serial bus: a free running double-rate clock, frame sync and line data.
   Assumes the device raises a line enable only while it drives that line. */
`timescale 1ns/1ps
module tsa_bus_model #(
  parameter int FRAME_BITS = 96
) (
  output logic doubleRateClock,
  output logic frameSync,
  output logic upstreamLineIn,
  output logic downstreamLineIn,
  input wire logic upstreamLineOut,
  input wire logic upstreamLineOe,
  input wire logic downstreamLineOut,
  input wire logic downstreamLineOe
);
  int halfCnt = 0;
  logic farBit;
  initial doubleRateClock = 1'b0;
  always #40 doubleRateClock = ~doubleRateClock;
  // Two clock periods make one bit and sync marks bit zero.
  always @(negedge doubleRateClock) begin
    halfCnt <= (halfCnt == 2 * FRAME_BITS - 1) ? 0 : halfCnt + 1;
  end
  assign frameSync = (halfCnt < 2);
  // The idle pattern changes every bit except at each eight-bit boundary, so a stale sample inside a byte never passes.
  assign farBit = halfCnt[1] ^ halfCnt[4];
  assign upstreamLineIn = upstreamLineOe ? upstreamLineOut : ~farBit;
  assign downstreamLineIn = downstreamLineOe ? downstreamLineOut : farBit;
endmodule : tsa_bus_model

// ### bench/testbench.sv
/* Self-checking bench of the timeslot access block over AXI4-Lite.
   Assumes the bus model drives clock, sync and idle line data. */
`timescale 1ns/1ps
module testbench
  import tsa_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  tsa_axi_req_t axiReq = '0;
  tsa_axi_rsp_t axiRsp;
  logic lineTxReady = 1'b1;
  logic lineRxData = 1'b0;
  logic doubleRateClock, frameSync, upstreamLineIn, downstreamLineIn;
  logic upstreamLineOut, upstreamLineOe, downstreamLineOut, downstreamLineOe;
  logic strobeOutOne, strobeOutTwo, lineTxValid, lineRxReady;
  logic [1:0] lineTxData;
  logic s1Q, s2Q, fsQ;
  logic [31:0] rdD;
  logic [1:0] rdR;
  int miscompares = 0;
  int cmp_count = 0;
  int cur[7] = '{default: 0};
  int last[7] = '{default: 0};
  logic [2:0] enTab[5] = '{3'h1, 3'h4, 3'h5, 3'h3, 3'h7};
  logic [31:0] bitTab[5] = '{32'h8, 32'h2, 32'hA, 32'h10, 32'h12};
  always #5 core_clk = ~core_clk;
  tsa_top dut (.core_clk, .srst, .axiReq, .axiRsp, .doubleRateClock, .frameSync,
    .upstreamLineIn, .upstreamLineOut, .upstreamLineOe, .downstreamLineIn,
    .downstreamLineOut, .downstreamLineOe, .strobeOutOne, .strobeOutTwo, .lineTxValid,
    .lineTxReady, .lineTxData, .lineRxValid(1'b1), .lineRxReady, .lineRxData);
  tsa_bus_model bus (.doubleRateClock, .frameSync, .upstreamLineIn, .downstreamLineIn,
    .upstreamLineOut, .upstreamLineOe, .downstreamLineOut, .downstreamLineOe);
  // Per-frame tallies: strobe rises, words out, bits fetched, flags, strobe one high, down drive.
  always @(posedge core_clk) begin
    s1Q <= strobeOutOne;
    s2Q <= strobeOutTwo;
    fsQ <= frameSync;
    if (lineRxReady) lineRxData <= ~lineRxData;
    if (frameSync && !fsQ) begin
      last <= cur;
      cur <= '{default: 0};
    end else begin
      cur[0] <= cur[0] + int'(strobeOutOne && !s1Q);
      cur[1] <= cur[1] + int'(strobeOutTwo && !s2Q);
      cur[2] <= cur[2] + int'(lineTxValid && lineTxReady);
      cur[3] <= cur[3] + int'(lineRxReady);
      cur[4] <= cur[4] + int'(lineTxValid && lineTxReady && lineTxData[1]);
      cur[5] <= cur[5] + int'(strobeOutOne);
      cur[6] <= cur[6] + int'(downstreamLineOe);
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1);
    axiReq.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1);
    rdD = axiRsp.rdata;
    rdR = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask : rd
  task automatic frames(input int n);
    repeat (n) @(posedge frameSync);
    repeat (2) @(posedge core_clk);
  endtask : frames
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    rd(OFS_MONITOR_CONTROL);
    chk("monitor_control", rdD, 32'h10);
    frames(2);
    rd(OFS_STATUS);
    chk("monitor rx master", rdD & 32'hFF, 32'hAA);
    chk("monitor drive", last[6], 32'h80);
    wr(OFS_MONITOR_CONTROL, 32'h50);
    frames(2);
    rd(OFS_STATUS);
    chk("monitor rx slave", rdD & 32'hFF, 32'h55);
    wr(OFS_MONITOR_CONTROL, 32'h33);
    frames(2);
    chk("terminal channel off", last[6], 32'h0);
    wr(OFS_FIRST_SLOT_CONFIG, 32'hFFFF_FFFF);
    rd(OFS_FIRST_SLOT_CONFIG);
    chk("first_slot_config", rdD, 32'hFF);
    rd(8'h24);
    chk("unmapped resp", {30'h0, rdR}, {30'h0, RESP_DECERR});
    wr(OFS_FIRST_SLOT_CONFIG, 32'h0);
    wr(OFS_SECOND_SLOT_CONFIG, 32'h81);
    foreach (enTab[i]) begin
      wr(OFS_FIFO_SLOT_CONTROL, {25'h0, enTab[i], 4'h1});
      frames(3);
      chk("bits to line", last[2], bitTab[i]);
      chk("bits from line", last[3], bitTab[i]);
      chk("frame flags", last[4], 32'h1);
    end
    // A stalled line side must overflow the buffer within one frame of 18 bits.
    lineTxReady <= 1'b0;
    frames(2);
    rd(OFS_STATUS);
    chk("overflow", rdD & 32'h100, 32'h100);
    lineTxReady <= 1'b1;
    wr(OFS_STATUS, 32'h100);
    rd(OFS_STATUS);
    chk("overflow clear", rdD & 32'h100, 32'h0);
    wr(OFS_STROBE_CONTROL_ONE, 32'h703);
    wr(OFS_STROBE_CONTROL_TWO, 32'h504);
    wr(OFS_STROBE_CONFIGURATION, 32'h2);
    frames(3);
    chk("strobe one pulses", last[0], 32'h2);
    chk("strobe one length", last[5], 32'h120);
    chk("strobe two clocks", last[1], 32'hA);
    wr(OFS_STROBE_CONFIGURATION, 32'h1);
    frames(3);
    chk("strobe one clocks", last[0], 32'h12);
    chk("strobe one gated", last[5], 32'h90);
    chk("strobe two pulses", last[1], 32'h2);
    complete_run();
  end
  initial begin
    #800000;
    miscompares++;
    complete_run();
  end
endmodule : testbench
